/* design/bms_boot_sequencer.sv */
// boot mode selection sequencer with avalon-mm status port
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - memory mode pin low at reset: program counter starts at rom 0000h.
// - global interrupt mask set before any boot transfer.
// - block zero into program space, single-access ram mapped, overlay off.
// - seven wait states on all external accesses during boot.
// - global data window 8000h-FFFFh enabled at boot start.
// - global window disabled on the same edge that asserts the jump to the destination.
// - selection word read at FFFFh with bus request and data strobe low.
// - only the low byte of the selection word is decoded.
// - kind 00: bits 3:2 pick serial 8/16 or parallel io 8/16.
// - kind 01/10: eprom 8/16 boot, bits 7:2 give source page.
// - kind 11: warm boot, bits 7:2 give the jump page.
// - host probe: interrupt out low, wait 10 output clocks, sample flag.
// - flag set: jump to host ram at 8800h.
// - flag clear: fetch and decode the selection word.
// - low level on external interrupt three sets the flag bit.
// - shared access mode bit held at 1 throughout boot.
// - host interrupt stays low until host writes the control register.
module bms_boot_sequencer #(
    parameter int CLK_PER_OUT = 2
) (
    input  wire logic                     mclk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     memory_mode_select_pin_i,
    input  wire logic                     external_interrupt_three_n_i,
    input  wire logic                     host_ctrl_write_i,
    input  wire logic [15:0]              mem_rdata_i,
    input  wire logic                     mem_ready_i,
    input  wire logic                     xfer_done_i,
    output logic                          bus_request_n_o,
    output logic                          data_strobe_n_o,
    output logic [15:0]                   mem_addr_o,
    output logic                          host_interrupt_out_n_o,
    output logic                          global_interrupt_mask_o,
    output logic                          block_zero_program_map_o,
    output logic                          single_ram_program_map_o,
    output logic                          data_overlay_enable_o,
    output logic [2:0]                    wait_states_o,
    output logic                          global_window_enable_o,
    output logic                          shared_access_mode_bit_o,
    output logic                          xfer_start_o,
    output bms_pkg::bms_mode_e            xfer_mode_o,
    output logic                          xfer_wide_o,
    output logic [bms_pkg::BMS_PAGE_W-1:0] source_page_field_o,
    output logic                          jump_o,
    output logic [15:0]                   jump_addr_o,
    output logic                          boot_busy_o,
    input  wire logic [1:0]               avs_address_i,
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [31:0]              avs_writedata_i,
    output logic [31:0]                   avs_readdata_o,
    output logic                          avs_waitrequest_o
);
    import bms_pkg::*;

    localparam logic [1:0] REG_STATUS  = 2'h0;
    localparam logic [1:0] REG_CONTROL = 2'h1;
    localparam logic [1:0] REG_SELWORD = 2'h2;

    bms_state_e state_r;
    logic [7:0] div_r;
    logic [7:0] probe_r;
    logic       iflag_r;
    logic       start_req_r;
    logic       rom_boot_r;
    logic [7:0] sel_r;
    logic       ack_r;

    // output clock tick from the core clock divider
    wire out_tick = (div_r == 8'(CLK_PER_OUT - 1));

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || out_tick) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // memory mode pin sampled once after reset release
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            start_req_r <= 1'b1;
            rom_boot_r  <= 1'b0;
        end else if (start_req_r) begin
            start_req_r <= 1'b0;
            rom_boot_r  <= !memory_mode_select_pin_i;
        end
    end

    // interrupt flag; set by a low external interrupt three, cleared only by reset
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            iflag_r <= 1'b0;
        end else if (!external_interrupt_three_n_i) begin
            iflag_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_r <= BMS_ST_IDLE;
            probe_r <= 8'h00;
        end else begin
            case (state_r)
                BMS_ST_IDLE: begin
                    if (!start_req_r && rom_boot_r) begin
                        state_r <= BMS_ST_SETUP;
                    end
                end
                BMS_ST_SETUP: begin
                    probe_r <= 8'h00;
                    state_r <= BMS_ST_PROBE;
                end
                BMS_ST_PROBE: begin
                    if (probe_r == 8'(BMS_PROBE_CYCLES)) begin
                        state_r <= iflag_r ? BMS_ST_CLOSE : BMS_ST_FETCH;
                    end else if (out_tick) begin
                        probe_r <= probe_r + 8'h01;
                    end
                end
                BMS_ST_FETCH: begin
                    if (mem_ready_i) begin
                        state_r <= (mem_rdata_i[1:0] == BMS_KIND_WARM) ? BMS_ST_CLOSE : BMS_ST_XFER;
                    end
                end
                BMS_ST_XFER: begin
                    if (xfer_done_i) begin
                        state_r <= BMS_ST_CLOSE;
                    end
                end
                BMS_ST_CLOSE: state_r <= BMS_ST_DONE;
                BMS_ST_DONE:  state_r <= BMS_ST_DONE;
                default:      state_r <= BMS_ST_IDLE;
            endcase
        end
    end

    // selection word and decode
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sel_r               <= 8'h00;
            xfer_mode_o         <= BMS_MODE_NONE;
            xfer_wide_o         <= 1'b0;
            source_page_field_o <= '0;
        end else if (state_r == BMS_ST_PROBE && probe_r == 8'(BMS_PROBE_CYCLES) && iflag_r) begin
            xfer_mode_o <= BMS_MODE_HOST;
        end else if (state_r == BMS_ST_FETCH && mem_ready_i) begin
            sel_r               <= mem_rdata_i[7:0];
            source_page_field_o <= mem_rdata_i[BMS_PAGE_LSB +: BMS_PAGE_W];
            case (mem_rdata_i[BMS_KIND_LSB +: 2])
                BMS_KIND_SER_IO: begin
                    xfer_mode_o <= mem_rdata_i[BMS_IO_BIT] ? BMS_MODE_PIO : BMS_MODE_SERIAL;
                    xfer_wide_o <= mem_rdata_i[BMS_WIDTH_BIT];
                end
                BMS_KIND_EPROM8: begin
                    xfer_mode_o <= BMS_MODE_EPROM;
                    xfer_wide_o <= 1'b0;
                end
                BMS_KIND_EPROM16: begin
                    xfer_mode_o <= BMS_MODE_EPROM;
                    xfer_wide_o <= 1'b1;
                end
                default: begin
                    xfer_mode_o <= BMS_MODE_WARM;
                    xfer_wide_o <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            xfer_start_o <= 1'b0;
        end else begin
            xfer_start_o <= state_r == BMS_ST_FETCH && mem_ready_i && mem_rdata_i[1:0] != BMS_KIND_WARM;
        end
    end

    // global read of the selection word
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bus_request_n_o <= 1'b1;
            data_strobe_n_o <= 1'b1;
            mem_addr_o      <= BMS_ROM_START;
        end else if (state_r == BMS_ST_PROBE && probe_r == 8'(BMS_PROBE_CYCLES) && !iflag_r) begin
            bus_request_n_o <= 1'b0;
            data_strobe_n_o <= 1'b0;
            mem_addr_o      <= BMS_SEL_WORD_ADDR;
        end else if (state_r == BMS_ST_FETCH && mem_ready_i) begin
            bus_request_n_o <= 1'b1;
            data_strobe_n_o <= 1'b1;
        end
    end

    // host interrupt; released only by a host control write
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            host_interrupt_out_n_o <= 1'b1;
        end else if (state_r == BMS_ST_SETUP) begin
            host_interrupt_out_n_o <= 1'b0;
        end else if (host_ctrl_write_i) begin
            host_interrupt_out_n_o <= 1'b1;
        end
    end

    // core configuration for the boot
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            global_interrupt_mask_o  <= 1'b0;
            block_zero_program_map_o <= 1'b0;
            single_ram_program_map_o <= 1'b0;
            data_overlay_enable_o    <= 1'b0;
            wait_states_o            <= 3'h0;
            global_window_enable_o   <= 1'b0;
            shared_access_mode_bit_o <= 1'b0;
        end else if (state_r == BMS_ST_SETUP) begin
            global_interrupt_mask_o  <= 1'b1;
            block_zero_program_map_o <= 1'b1;
            single_ram_program_map_o <= 1'b1;
            data_overlay_enable_o    <= 1'b0;
            wait_states_o            <= BMS_WAIT_STATES;
            global_window_enable_o   <= 1'b1;
            shared_access_mode_bit_o <= 1'b1;
        end else if (state_r == BMS_ST_CLOSE) begin
            global_window_enable_o   <= 1'b0;
        end
    end

    // jump asserted on the same edge that closes the window
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            jump_o      <= 1'b0;
            jump_addr_o <= BMS_ROM_START;
            boot_busy_o <= 1'b0;
        end else begin
            jump_o      <= state_r == BMS_ST_CLOSE;
            boot_busy_o <= state_r != BMS_ST_IDLE && state_r != BMS_ST_DONE;
            if (state_r == BMS_ST_CLOSE) begin
                jump_addr_o <= (xfer_mode_o == BMS_MODE_HOST) ? BMS_HOST_RAM_START
                             : {source_page_field_o, 10'h000};
            end
        end
    end

    // avalon slave: one wait cycle per access
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ack_r          <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            ack_r <= (avs_read_i || avs_write_i) && !ack_r;
            if (avs_read_i && !ack_r) begin
                if (avs_address_i == REG_STATUS) begin
                    avs_readdata_o <= {17'h00000, state_r, iflag_r, host_interrupt_out_n_o,
                                       global_window_enable_o, boot_busy_o, rom_boot_r, xfer_mode_o};
                end else if (avs_address_i == REG_CONTROL) begin
                    avs_readdata_o <= {29'h0, wait_states_o};
                end else if (avs_address_i == REG_SELWORD) begin
                    avs_readdata_o <= {24'h000000, sel_r};
                end else begin
                    avs_readdata_o <= 32'h0000_0000;
                end
            end
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
endmodule : bms_boot_sequencer

`default_nettype wire

/* design/bms_pkg.sv */
// package for the boot mode selection sequencer
package bms_pkg;
    localparam logic [15:0] BMS_ROM_START      = 16'h0000;
    localparam logic [15:0] BMS_HOST_RAM_START = 16'h8800;
    localparam logic [15:0] BMS_SEL_WORD_ADDR  = 16'hFFFF;
    localparam logic [15:0] BMS_GLOBAL_LO      = 16'h8000;
    localparam logic [15:0] BMS_GLOBAL_HI      = 16'hFFFF;
    localparam logic [2:0]  BMS_WAIT_STATES    = 3'h7;
    // output_clock cycles held before sampling the interrupt flag
    localparam int          BMS_PROBE_CYCLES   = 10;
    // field positions of the low selection byte
    localparam int          BMS_KIND_LSB       = 0;
    localparam int          BMS_WIDTH_BIT      = 2;
    localparam int          BMS_IO_BIT         = 3;
    localparam int          BMS_PAGE_LSB       = 2;
    localparam int          BMS_PAGE_W         = 6;
    localparam logic [1:0]  BMS_KIND_SER_IO    = 2'h0;
    localparam logic [1:0]  BMS_KIND_EPROM8    = 2'h1;
    localparam logic [1:0]  BMS_KIND_EPROM16   = 2'h2;
    localparam logic [1:0]  BMS_KIND_WARM      = 2'h3;

    typedef enum logic [2:0] {
        BMS_MODE_NONE   = 3'h0,
        BMS_MODE_SERIAL = 3'h1,
        BMS_MODE_PIO    = 3'h2,
        BMS_MODE_EPROM  = 3'h3,
        BMS_MODE_WARM   = 3'h4,
        BMS_MODE_HOST   = 3'h5
    } bms_mode_e;

    typedef enum logic [6:0] {
        BMS_ST_IDLE  = 7'h01,
        BMS_ST_SETUP = 7'h02,
        BMS_ST_PROBE = 7'h04,
        BMS_ST_FETCH = 7'h08,
        BMS_ST_XFER  = 7'h10,
        BMS_ST_CLOSE = 7'h20,
        BMS_ST_DONE  = 7'h40
    } bms_state_e;
endpackage : bms_pkg

/* dv/bms_boot_sequencer_assertions.sv */
// port checker for the boot mode selection sequencer
`timescale 1ns/1ps
`default_nettype none
module bms_boot_sequencer_assertions (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        host_ctrl_write_i,
    input wire logic        bus_request_n_o,
    input wire logic        data_strobe_n_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic        host_interrupt_out_n_o,
    input wire logic        global_interrupt_mask_o,
    input wire logic        block_zero_program_map_o,
    input wire logic        single_ram_program_map_o,
    input wire logic        data_overlay_enable_o,
    input wire logic [2:0]  wait_states_o,
    input wire logic        global_window_enable_o,
    input wire logic        shared_access_mode_bit_o,
    input wire logic        xfer_start_o,
    input wire logic        jump_o,
    input wire logic        boot_busy_o
);
    logic [7:0] probe_cnt_r;
    // saturating count of cycles since the host interrupt went low
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || host_interrupt_out_n_o) begin
            probe_cnt_r <= 8'h00;
        end else if (probe_cnt_r != 8'hFF) begin
            probe_cnt_r <= probe_cnt_r + 8'h01;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    mask_set_a: assert property (boot_busy_o |-> global_interrupt_mask_o)
        else $error("interrupt mask clear during boot");
    mem_map_a: assert property (boot_busy_o |-> block_zero_program_map_o && single_ram_program_map_o
        && !data_overlay_enable_o) else $error("memory map wrong during boot");
    wait_states_a: assert property (boot_busy_o |-> wait_states_o == 3'h7)
        else $error("wait states not seven during boot");
    window_on_a: assert property ($fell(host_interrupt_out_n_o) |-> global_window_enable_o)
        else $error("global window off at boot start");
    jump_window_a: assert property (jump_o |-> !global_window_enable_o)
        else $error("global window still on at jump");
    fetch_addr_a: assert property (!bus_request_n_o |-> !data_strobe_n_o && mem_addr_o == 16'hFFFF)
        else $error("selection fetch not strobed at FFFFh");
    probe_wait_a: assert property (($fell(bus_request_n_o) || jump_o) |-> probe_cnt_r >= 8'd19)
        else $error("probe ended before ten output clocks");
    probe_end_a: assert property ($fell(host_interrupt_out_n_o) |-> ##[18:40] (!bus_request_n_o || jump_o))
        else $error("probe never ended");
    shared_mode_a: assert property (boot_busy_o |-> shared_access_mode_bit_o)
        else $error("shared access bit low during boot");
    host_interrupt_out_n_hold_a: assert property (!host_interrupt_out_n_o && !host_ctrl_write_i |=> !host_interrupt_out_n_o)
        else $error("host interrupt released without host write");
    jump_cov: cover property (jump_o);
    xfer_cov: cover property (xfer_start_o);
    fetch_cov: cover property ($fell(bus_request_n_o));
endmodule : bms_boot_sequencer_assertions
bind bms_boot_sequencer bms_boot_sequencer_assertions u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .host_ctrl_write_i(host_ctrl_write_i), .bus_request_n_o(bus_request_n_o), .data_strobe_n_o(data_strobe_n_o),
    .mem_addr_o(mem_addr_o), .host_interrupt_out_n_o(host_interrupt_out_n_o),
    .global_interrupt_mask_o(global_interrupt_mask_o), .block_zero_program_map_o(block_zero_program_map_o),
    .single_ram_program_map_o(single_ram_program_map_o), .data_overlay_enable_o(data_overlay_enable_o),
    .wait_states_o(wait_states_o), .global_window_enable_o(global_window_enable_o),
    .shared_access_mode_bit_o(shared_access_mode_bit_o), .xfer_start_o(xfer_start_o), .jump_o(jump_o),
    .boot_busy_o(boot_busy_o));
`default_nettype wire

/* dv/bms_boot_sequencer_test.sv */
// self-checking bench for the boot mode selection sequencer
`timescale 1ns/1ps
`default_nettype none
module bms_boot_sequencer_test;
    import bms_pkg::*;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, pin = 1'b0, hwr = 1'b0, lp = 1'b0, sl = 1'b0;
    logic avs_rd = 1'b0, avs_wr = 1'b0;
    logic [1:0] avs_a = 2'h0;
    logic [15:0] sel = 16'h0000, rdata, addr, jaddr;
    logic ready, external_interrupt_three_n, done, breq_n, ds_n, host_interrupt_out_n_n, jmp, xstart, xwide, win, busy, avs_wait;
    logic [2:0] ws;
    logic [5:0] page;
    logic [31:0] avs_q, rd;
    bms_mode_e xmode;
    logic s_start, s_fetch, s_win, s_wide;
    logic [2:0] s_mode;
    logic [5:0] s_page;
    int n_errors = 0, tests_run = 0;
    always #4 mclk_i = ~mclk_i;
    bms_boot_sequencer u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .memory_mode_select_pin_i(pin),
        .external_interrupt_three_n_i(external_interrupt_three_n), .host_ctrl_write_i(hwr), .mem_rdata_i(rdata), .mem_ready_i(ready),
        .xfer_done_i(done), .bus_request_n_o(breq_n), .data_strobe_n_o(ds_n), .mem_addr_o(addr),
        .host_interrupt_out_n_o(host_interrupt_out_n_n), .global_interrupt_mask_o(), .block_zero_program_map_o(),
        .single_ram_program_map_o(), .data_overlay_enable_o(), .wait_states_o(ws), .global_window_enable_o(win),
        .shared_access_mode_bit_o(), .xfer_start_o(xstart), .xfer_mode_o(xmode), .xfer_wide_o(xwide),
        .source_page_field_o(page), .jump_o(jmp), .jump_addr_o(jaddr), .boot_busy_o(busy), .avs_address_i(avs_a),
        .avs_read_i(avs_rd), .avs_write_i(avs_wr), .avs_writedata_i(32'h0), .avs_readdata_o(avs_q),
        .avs_waitrequest_o(avs_wait));
    bms_far_model u_far (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_request_n_i(breq_n), .data_strobe_n_i(ds_n),
        .mem_addr_i(addr), .host_interrupt_out_n_i(host_interrupt_out_n_n), .xfer_start_i(xstart), .sel_word_i(sel),
        .loop_en_i(lp), .slow_i(sl), .mem_rdata_o(rdata), .mem_ready_o(ready), .external_interrupt_three_n_o(external_interrupt_three_n),
        .xfer_done_o(done));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic reset_to(input logic [15:0] w, input logic l, input logic s);
        // selection word, loopback and slow mode settled while reset holds
        @(posedge mclk_i);
        sel <= w; lp <= l; sl <= s; rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
    endtask : reset_to
    task automatic boot(input logic [15:0] w, input logic l, input logic s);
        int i;
        reset_to(w, l, s);
        s_start = 1'b0; s_fetch = 1'b0;
        for (i = 0; i < 400 && jmp !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
            if (breq_n === 1'b0) s_fetch = 1'b1;
            if (xstart === 1'b1) begin
                s_start = 1'b1; s_mode = xmode; s_wide = xwide; s_page = page;
            end
        end
        s_win = win;
        if (jmp !== 1'b1) begin
            chk("boot completion", 1, 0);
            end_sim();
        end
    endtask : boot
    task automatic avs_read(input logic [1:0] a, output logic [31:0] d);
        int i;
        @(posedge mclk_i);
        avs_rd <= 1'b1; avs_a <= a;
        for (i = 0; i < 20; i++) begin
            #1;
            if (avs_wait === 1'b0) break;
            @(posedge mclk_i);
        end
        if (i == 20) begin
            chk("avalon answer", 1, 0);
            end_sim();
        end
        d = avs_q;
        @(posedge mclk_i);
        avs_rd <= 1'b0;
    endtask : avs_read
    task automatic t_pin();
        pin <= 1'b1;
        reset_to(16'h0000, 1'b1, 1'b0);
        repeat (60) @(posedge mclk_i);
        #1;
        chk("no boot host_interrupt_out_n", 1, host_interrupt_out_n_n);
        chk("no boot fetch", 1, breq_n);
        pin <= 1'b0;
        $display("t_pin done");
    endtask : t_pin
    task automatic t_host();
        boot(16'h0001, 1'b1, 1'b0);
        chk("host jump addr", 32'h8800, jaddr);
        chk("host skips fetch", 0, s_fetch);
        chk("window at jump", 0, s_win);
        repeat (3) @(posedge mclk_i);
        #1;
        chk("host_interrupt_out_n held", 0, host_interrupt_out_n_n);
        @(posedge mclk_i);
        hwr <= 1'b1;
        @(posedge mclk_i);
        hwr <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        chk("host_interrupt_out_n released", 1, host_interrupt_out_n_n);
        $display("t_host done");
    endtask : t_host
    task automatic t_modes();
        logic [15:0] tbl [7] = '{16'hA500, 16'h5A04, 16'hFF08, 16'h000C, 16'h12B5, 16'h807E, 16'h3CC3};
        logic [1:0] k;
        for (int i = 0; i < 7; i++) begin
            boot(tbl[i], 1'b0, i[0]);
            k = tbl[i][1:0];
            chk("fetch done", 1, s_fetch);
            chk("xfer started", k != 2'h3, s_start);
            if (k != 2'h3) chk("mode", k == 2'h0 ? (tbl[i][3] ? 3'h2 : 3'h1) : 3'h3, s_mode);
            if (k != 2'h3) chk("wide", k == 2'h0 ? tbl[i][2] : k == 2'h2, s_wide);
            if (k != 2'h0) chk("page", tbl[i][7:2], (k == 2'h3) ? page : s_page);
            if (k != 2'h0) chk("jump addr", {tbl[i][7:2], 10'h000}, jaddr);
        end
        $display("t_modes done");
    endtask : t_modes
    task automatic t_regs();
        avs_read(2'h2, rd);
        chk("selection byte", 32'hC3, rd);
        avs_read(2'h3, rd);
        chk("unmapped read", 0, rd);
        $display("t_regs done");
    endtask : t_regs
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_pin();
        t_host();
        t_modes();
        t_regs();
        end_sim();
    end
endmodule : bms_boot_sequencer_test
`default_nettype wire

/* dv/bms_far_model.sv */
// boot memory, transfer engine and loopback wiring model
`timescale 1ns/1ps
`default_nettype none
module bms_far_model (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        bus_request_n_i,
    input  wire logic        data_strobe_n_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic        host_interrupt_out_n_i,
    input  wire logic        xfer_start_i,
    input  wire logic [15:0] sel_word_i,
    input  wire logic        loop_en_i,
    input  wire logic        slow_i,
    output logic [15:0]      mem_rdata_o,
    output logic             mem_ready_o,
    output logic             external_interrupt_three_n_o,
    output logic             xfer_done_o
);
    logic [3:0] dly_r;
    logic [3:0] done_r;
    assign external_interrupt_three_n_o = loop_en_i ? host_interrupt_out_n_i : 1'b1;
    // data lines show the inverse whenever ready is low, never a stale word
    assign mem_rdata_o = mem_ready_o ? sel_word_i : ~sel_word_i;
    assign mem_ready_o = dly_r == (slow_i ? 4'h5 : 4'h1);
    assign xfer_done_o = done_r[3];
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || bus_request_n_i || data_strobe_n_i || mem_addr_i != 16'hFFFF) begin
            dly_r <= 4'h0;
        end else if (dly_r != 4'hF) begin
            dly_r <= dly_r + 4'h1;
        end
    end
    always_ff @(posedge mclk_i) begin
        done_r <= rst_n_i ? {done_r[2:0], xfer_start_i} : 4'h0;
    end
endmodule : bms_far_model
`default_nettype wire
